// ===== verilog/fault_pkg.sv
// Package: register map, field layouts and shared types for the fault/wide-register block
package fault_pkg;

    // ---------------------------------------------------------------
    // Register byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_COUNTER   = 8'h00;
    localparam logic [7:0] ADDR_CMP_A     = 8'h04;
    localparam logic [7:0] ADDR_CMP_B     = 8'h08;
    localparam logic [7:0] ADDR_CMP_C     = 8'h0C;
    localparam logic [7:0] ADDR_CMP_D     = 8'h10;
    localparam logic [7:0] ADDR_HIGH_LAT  = 8'h14;
    localparam logic [7:0] ADDR_CTRL_D    = 8'h18;
    localparam logic [7:0] ADDR_COM_MODE  = 8'h1C;
    localparam logic [7:0] ADDR_PORT_B    = 8'h20;
    localparam logic [7:0] ADDR_STATUS    = 8'h24;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int WIDE_W = 10;
    localparam int HIGH_W = 2;
    localparam int LOW_W = 8;
    localparam int COM_W = 8;
    localparam int PWM_PINS = 6;
    localparam int FILTER_SAMPLES = 4;

    // ---------------------------------------------------------------
    // Control D bit positions
    // ---------------------------------------------------------------
    localparam int CD_PROT_EN = 7;
    localparam int CD_IRQ_EN = 6;
    localparam int CD_FILTER_EN = 5;
    localparam int CD_EDGE_RISE = 4;
    localparam int CD_SRC_CMP = 3;
    localparam int CD_FLAG = 2;

    // Status bit positions
    localparam int ST_FLAG = 0;
    localparam int ST_PROT_EN = 1;
    localparam int ST_IRQ = 2;

    localparam logic [7:0] CTRL_D_RESET = 8'h00;
    localparam logic [WIDE_W-1:0] WIDE_RESET = 10'h000;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic prot_en;
        logic irq_en;
        logic filter_en;
        logic edge_rise;
        logic src_cmp;
    } fault_cfg_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } ahb_req_t;

endpackage

// ===== verilog/fault_filter.sv
// Synchroniser, optional four-sample noise filter and edge detector
`timescale 1ns/1ns
module fault_filter #(
    parameter int SAMPLES = 4
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_async,
    input wire logic i_filter_en,
    input wire logic i_edge_rise,
    output logic o_edge
);
    logic sync1_q;
    logic sync2_q;
    logic [SAMPLES-2:0] hist_q;
    logic [SAMPLES-1:0] window;
    logic filt_q;
    logic prev_q;
    logic level;

    // ---------------------------------------------------------------
    // Two-stage synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= i_async;
            sync2_q <= sync1_q;
        end
    end

    // ---------------------------------------------------------------
    // Noise filter on system clock
    // ---------------------------------------------------------------
    // Newest sample joins the stored ones, so latency is exactly SAMPLES
    assign window = {hist_q, sync2_q};

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hist_q <= '0;
            filt_q <= 1'b0;
        end else begin
            hist_q <= window[SAMPLES-2:0];
            if (&window) begin
                filt_q <= 1'b1;
            end else if (~|window) begin
                filt_q <= 1'b0;
            end
        end
    end

    assign level = i_filter_en ? filt_q : sync2_q;

    // ---------------------------------------------------------------
    // Edge detector
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_q <= 1'b0;
            o_edge <= 1'b0;
        end else begin
            prev_q <= level;
            o_edge <= i_edge_rise ? (level & ~prev_q) : (~level & prev_q);
        end
    end

endmodule

// ===== verilog/pwm_fault_shutdown.sv
// Fault shutdown and 10-bit register access for the high-speed PWM timer
//
// How it works
// - An enabled edge of the selected fault input enters fault protection mode.
// - On fault, compare-output modes clear and pins take port B latch bits.
// - Protect enable self-clears in the same cycle the mode bits clear.
// - With interrupt enable set, a fault raises an interrupt request.
// - Source is external pin by default, comparator when select bit set.
// - Source change may trigger a fault; software clears flag afterwards.
// - Both inputs use the same synchroniser and edge detector as count input.
// - Filter output changes only after four agreeing samples.
// - Filter enable inserts filter, adding four cycles of latency.
// - Filter runs on the system clock, independent of prescaler.
// - Software driving the external pin port output can trigger a fault.
// - Counter and compare A-D are 10 bits sharing one 2-bit high latch.
// - Low-byte write loads latch and low byte together in one cycle.
// - Low-byte read copies upper two bits into latch in the same cycle.
// - Latch value persists across low-byte writes.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module pwm_fault_shutdown
    import fault_pkg::*;
#(
    parameter int FILTER_N = FILTER_SAMPLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_ext_irq_pin_zero,
    input wire logic i_comparator_result,
    input wire logic [PWM_PINS-1:0] i_pwm_wave,
    output logic [PWM_PINS-1:0] o_pwm_pins,
    output logic o_fault_irq,
    output logic o_ext_pin_drive,
    output logic [WIDE_W-1:0] o_counter_value,
    output logic [WIDE_W-1:0] o_cmp_a,
    output logic [WIDE_W-1:0] o_cmp_b,
    output logic [WIDE_W-1:0] o_cmp_c,
    output logic [WIDE_W-1:0] o_cmp_d
);
    import fault_pkg::*;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    fault_cfg_t cfg_q;
    logic fault_event_flag_q;
    logic [HIGH_W-1:0] shared_high_bits_latch_q;
    logic [WIDE_W-1:0] wide_q [5];
    logic [COM_W-1:0] compare_output_mode_bits_q;
    logic [7:0] port_b_output_latch_q;
    logic irq_q;
    logic [PWM_PINS-1:0] pins_q;
    logic ext_drive_q;

    // Address phase capture
    logic ph_valid_q;
    logic ph_write_q;
    logic [7:0] ph_addr_q;
    logic [31:0] rdata_q;

    logic take;
    logic wr;
    logic rd;
    logic fault_edge;
    logic fault_src;
    logic fault_hit;
    logic [2:0] wide_idx;
    logic wide_hit;
    logic [2:0] rd_idx;
    logic rd_wide;

    // ---------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ---------------------------------------------------------------
    assign take = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);
    assign wr = ph_valid_q & ph_write_q;
    assign rd = take & ~i_hwrite;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else begin
            ph_valid_q <= take;
            ph_write_q <= i_hwrite;
            ph_addr_q <= i_haddr[7:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    function automatic logic [2:0] wide_index(input logic [7:0] a);
        logic [2:0] idx;
        idx = 3'h7;
        unique case (a)
            ADDR_COUNTER: idx = 3'h0;
            ADDR_CMP_A: idx = 3'h1;
            ADDR_CMP_B: idx = 3'h2;
            ADDR_CMP_C: idx = 3'h3;
            ADDR_CMP_D: idx = 3'h4;
            default: idx = 3'h7;
        endcase
        return idx;
    endfunction

    assign wide_idx = wide_index(ph_addr_q);
    assign wide_hit = wr & (wide_idx != 3'h7);
    assign rd_idx = wide_index(i_haddr[7:0]);
    assign rd_wide = rd & (rd_idx != 3'h7);

    // Read data registered at the address phase
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= ZERO_WORD;
        end else if (rd) begin
            rdata_q <= ZERO_WORD;
            if (rd_wide) begin
                rdata_q[LOW_W-1:0] <= wide_q[rd_idx][LOW_W-1:0];
            end
            unique case (i_haddr[7:0])
                ADDR_HIGH_LAT: rdata_q[HIGH_W-1:0] <= shared_high_bits_latch_q;
                ADDR_CTRL_D: rdata_q[7:0] <= {cfg_q.prot_en, cfg_q.irq_en, cfg_q.filter_en,
                    cfg_q.edge_rise, cfg_q.src_cmp, fault_event_flag_q, 2'b00};
                ADDR_COM_MODE: rdata_q[COM_W-1:0] <= compare_output_mode_bits_q;
                ADDR_PORT_B: rdata_q[7:0] <= port_b_output_latch_q;
                ADDR_STATUS: begin
                    rdata_q[ST_FLAG] <= fault_event_flag_q;
                    rdata_q[ST_PROT_EN] <= cfg_q.prot_en;
                    rdata_q[ST_IRQ] <= irq_q;
                end
                default: ;
            endcase
        end
    end

    assign o_hrdata = rdata_q;

    // ---------------------------------------------------------------
    // Shared high-bits latch
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shared_high_bits_latch_q <= '0;
        end else if (rd_wide) begin
            shared_high_bits_latch_q <= wide_q[rd_idx][WIDE_W-1:LOW_W];
        end else if (wr && ph_addr_q == ADDR_HIGH_LAT) begin
            shared_high_bits_latch_q <= i_hwdata[HIGH_W-1:0];
        end
        // Low-byte writes leave the latch alone
    end

    // ---------------------------------------------------------------
    // 10-bit registers
    // ---------------------------------------------------------------
    generate
        for (genvar g = 0; g < 5; g++) begin : g_wide
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    wide_q[g] <= WIDE_RESET;
                end else if (wide_hit && wide_idx == 3'(g)) begin
                    wide_q[g] <= {shared_high_bits_latch_q, i_hwdata[LOW_W-1:0]};
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_counter_value <= WIDE_RESET;
            o_cmp_a <= WIDE_RESET;
            o_cmp_b <= WIDE_RESET;
            o_cmp_c <= WIDE_RESET;
            o_cmp_d <= WIDE_RESET;
        end else begin
            o_counter_value <= wide_q[0];
            o_cmp_a <= wide_q[1];
            o_cmp_b <= wide_q[2];
            o_cmp_c <= wide_q[3];
            o_cmp_d <= wide_q[4];
        end
    end

    // ---------------------------------------------------------------
    // Fault input path
    // ---------------------------------------------------------------
    // Port B bit 0 models the port output of the external pin
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_drive_q <= 1'b0;
        end else begin
            ext_drive_q <= port_b_output_latch_q[0];
        end
    end
    assign o_ext_pin_drive = ext_drive_q;

    assign fault_src = cfg_q.src_cmp ? i_comparator_result : (i_ext_irq_pin_zero | ext_drive_q);

    fault_filter #(
        .SAMPLES(FILTER_N)
    ) u_filter (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_async(fault_src),
        .i_filter_en(cfg_q.filter_en),
        .i_edge_rise(cfg_q.edge_rise),
        .o_edge(fault_edge)
    );

    assign fault_hit = fault_edge & cfg_q.prot_en;

    // ---------------------------------------------------------------
    // Control D and fault flag
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_q <= '0;
        end else begin
            if (wr && ph_addr_q == ADDR_CTRL_D) begin
                cfg_q.prot_en <= i_hwdata[CD_PROT_EN];
                cfg_q.irq_en <= i_hwdata[CD_IRQ_EN];
                cfg_q.filter_en <= i_hwdata[CD_FILTER_EN];
                cfg_q.edge_rise <= i_hwdata[CD_EDGE_RISE];
                cfg_q.src_cmp <= i_hwdata[CD_SRC_CMP];
            end
            if (fault_hit) begin
                cfg_q.prot_en <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fault_event_flag_q <= 1'b0;
        end else if (fault_edge) begin
            fault_event_flag_q <= 1'b1;
        end else if (wr && ph_addr_q == ADDR_CTRL_D && i_hwdata[CD_FLAG]) begin
            fault_event_flag_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Compare-output modes and port B latch
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            compare_output_mode_bits_q <= '0;
        end else if (fault_hit) begin
            compare_output_mode_bits_q <= '0;
        end else if (wr && ph_addr_q == ADDR_COM_MODE) begin
            compare_output_mode_bits_q <= i_hwdata[COM_W-1:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port_b_output_latch_q <= 8'h00;
        end else if (wr && ph_addr_q == ADDR_PORT_B) begin
            port_b_output_latch_q <= i_hwdata[7:0];
        end
    end

    // Pin pair k is driven by the waveform while its mode field is non-zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pins_q <= '0;
        end else begin
            for (int k = 0; k < PWM_PINS; k++) begin
                pins_q[k] <= (|compare_output_mode_bits_q[2*(k/2) +: 2]) ?
                    i_pwm_wave[k] : port_b_output_latch_q[k];
            end
        end
    end
    assign o_pwm_pins = pins_q;

    // ---------------------------------------------------------------
    // Interrupt request, held until the flag is cleared
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_q <= 1'b0;
        end else if (fault_hit && cfg_q.irq_en) begin
            irq_q <= 1'b1;
        end else if (!fault_event_flag_q) begin
            irq_q <= 1'b0;
        end
    end
    assign o_fault_irq = irq_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_fault_clears_mode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        fault_hit |=> compare_output_mode_bits_q == '0)
        else $error("mode bits not cleared on fault");
    a_enable_self_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        fault_hit |=> !cfg_q.prot_en && compare_output_mode_bits_q == '0)
        else $error("enable not cleared with mode bits");
    a_irq_on_fault: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (fault_hit && cfg_q.irq_en) |=> irq_q)
        else $error("fault irq missing");
    a_flag_on_edge: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        fault_edge |=> fault_event_flag_q)
        else $error("fault flag not set");
    a_low_write_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        wide_hit |=> wide_q[$past(wide_idx)] ==
            {$past(shared_high_bits_latch_q), $past(i_hwdata[LOW_W-1:0])})
        else $error("wide write wrong");
    a_low_read_latch: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        rd_wide |=> shared_high_bits_latch_q == $past(wide_q[rd_idx][WIDE_W-1:LOW_W]))
        else $error("latch not loaded on read");
    a_latch_persists: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (wide_hit && !rd_wide) |=> $stable(shared_high_bits_latch_q))
        else $error("latch changed on low write");
    a_no_fault_disabled: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (fault_edge && !cfg_q.prot_en) |=> $stable(compare_output_mode_bits_q)
            || $past(wr))
        else $error("fault acted while disabled");

endmodule

// ===== tb/fault_far_end.sv
// Far-side model: fault pin, comparator output and timer waveform
`timescale 1ns/1ns
module fault_far_end
    import fault_pkg::*;
#(
    parameter logic [PWM_PINS-1:0] WAVE = 6'h15
) (
    input wire logic i_clk,
    output logic o_pin,
    output logic o_cmp,
    output logic [PWM_PINS-1:0] o_wave
);
    initial begin
        o_pin = 1'b0;
        o_cmp = 1'b1;
        o_wave = WAVE;
    end

    // Levels change just after a rising edge
    task automatic set_pin(input logic v);
        @(posedge i_clk);
        o_pin <= v;
    endtask

    task automatic set_cmp(input logic v);
        @(posedge i_clk);
        o_cmp <= v;
    endtask

    // Short low pulse, shorter than the filter window
    task automatic glitch_cmp(input int n);
        @(posedge i_clk);
        o_cmp <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_cmp <= 1'b1;
    endtask
endmodule

// ===== tb/testbench.sv
// Testbench: bus access, wide registers and fault shutdown
`timescale 1ns/1ns
module testbench;
    import fault_pkg::*;
    logic i_clk, i_arst_n, i_hsel, i_hwrite, hready;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic o_hreadyout, o_hresp, o_fault_irq, o_ext_pin_drive, pin, cmp;
    logic [PWM_PINS-1:0] wave, o_pwm_pins;
    logic [WIDE_W-1:0] o_counter_value, o_cmp_a, o_cmp_b, o_cmp_c, o_cmp_d;
    int miscompares, n_tests, lat_plain, lat_filt;

    assign hready = o_hreadyout;

    fault_far_end i_far (.i_clk(i_clk), .o_pin(pin), .o_cmp(cmp), .o_wave(wave));

    pwm_fault_shutdown i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hwdata(i_hwdata), .i_hready(hready), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_ext_irq_pin_zero(pin),
        .i_comparator_result(cmp), .i_pwm_wave(wave), .o_pwm_pins(o_pwm_pins),
        .o_fault_irq(o_fault_irq), .o_ext_pin_drive(o_ext_pin_drive),
        .o_counter_value(o_counter_value), .o_cmp_a(o_cmp_a), .o_cmp_b(o_cmp_b),
        .o_cmp_c(o_cmp_c), .o_cmp_d(o_cmp_d));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // ---------------------------------------------------------------
    // Reporting
    // ---------------------------------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ---------------------------------------------------------------
    // Bus master
    // ---------------------------------------------------------------
    task automatic wait_ready();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge i_clk);
            if (hready === 1'b1) break;
        end
        if (i == 50) begin
            miscompares++;
            stop_test();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= HTRANS_NONSEQ;
        i_haddr <= {24'h00_0000, addr};
        i_hwrite <= wr;
        i_hsize <= 3'h2;
        wait_ready();
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wdata;
        wait_ready();
        rd = o_hrdata;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        ahb(1'b1, addr, data);
    endtask

    task automatic rd_check(input string name, input logic [7:0] addr, input logic [31:0] exp);
        ahb(1'b0, addr, ZERO_WORD);
        check(name, rd, exp);
    endtask

    // Cycles from a fault input change until the pins move
    task automatic pin_latency(output int lat);
        logic [PWM_PINS-1:0] prev;
        prev = o_pwm_pins;
        for (lat = 1; lat < 40; lat++) begin
            @(posedge i_clk);
            #1;
            if (o_pwm_pins !== prev) break;
        end
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        miscompares = 0;
        n_tests = 0;
        i_arst_n = 1'b0;
        i_hsel = 1'b0;
        i_haddr = ZERO_WORD;
        i_htrans = 2'h0;
        i_hwrite = 1'b0;
        i_hsize = 3'h2;
        i_hwdata = ZERO_WORD;
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        check("hresp", {31'h0, o_hresp}, 32'h0000_0000);
        rd_check("ctrl_rst", ADDR_CTRL_D, 32'h0000_0000);
        rd_check("status_rst", ADDR_STATUS, 32'h0000_0000);
        rd_check("unmapped", 8'h40, 32'h0000_0000);
        // Latch then low byte for all five wide registers
        for (int k = 0; k < 5; k++) begin
            wr(ADDR_HIGH_LAT, k % 4);
            wr(ADDR_COUNTER + 8'(4 * k), 32'h10 + k);
        end
        @(posedge i_clk);
        #1;
        check("counter", o_counter_value, 32'h010);
        check("cmp_a", o_cmp_a, 32'h111);
        check("cmp_b", o_cmp_b, 32'h212);
        check("cmp_c", o_cmp_c, 32'h313);
        check("cmp_d", o_cmp_d, 32'h014);
        wr(ADDR_HIGH_LAT, 32'h2);
        wr(ADDR_CMP_C, 32'h77);
        wr(ADDR_CMP_D, 32'h88);
        @(posedge i_clk);
        #1;
        check("cmp_c_reuse", o_cmp_c, 32'h277);
        check("cmp_d_reuse", o_cmp_d, 32'h288);
        wr(ADDR_HIGH_LAT, 32'h0);
        rd_check("cmp_b_low", ADDR_CMP_B, 32'h12);
        rd_check("cmp_b_high", ADDR_HIGH_LAT, 32'h2);
        rd_check("cmp_a_low", ADDR_CMP_A, 32'h11);
        rd_check("cmp_a_high", ADDR_HIGH_LAT, 32'h1);
        // Rising edge on the external pin, interrupt enabled
        wr(ADDR_COM_MODE, 32'hFF);
        wr(ADDR_PORT_B, 32'h2A);
        wr(ADDR_CTRL_D, 32'hD4);
        check("pins_wave", o_pwm_pins, 32'h15);
        i_far.set_pin(1'b1);
        pin_latency(lat_plain);
        check("pins_port", o_pwm_pins, 32'h2A);
        @(posedge i_clk);
        #1;
        check("irq", o_fault_irq, 32'h1);
        rd_check("mode_clr", ADDR_COM_MODE, 32'h0);
        rd_check("ctrl_fault", ADDR_CTRL_D, 32'h54);
        rd_check("status_fault", ADDR_STATUS, 32'h5);
        wr(ADDR_CTRL_D, 32'h54);
        repeat (2) @(posedge i_clk);
        #1;
        check("irq_clr", o_fault_irq, 32'h0);
        // Filtered falling edge from the comparator
        wr(ADDR_CTRL_D, 32'h28);
        repeat (12) @(posedge i_clk);
        wr(ADDR_CTRL_D, 32'hAC);
        wr(ADDR_COM_MODE, 32'hFF);
        i_far.glitch_cmp(2);
        repeat (20) @(posedge i_clk);
        rd_check("glitch", ADDR_STATUS, 32'h2);
        i_far.set_cmp(1'b0);
        pin_latency(lat_filt);
        check("filt_delay", lat_filt - lat_plain, FILTER_SAMPLES);
        for (int i = 0; i < 20; i++) begin
            ahb(1'b0, ADDR_STATUS, ZERO_WORD);
            if (rd[ST_PROT_EN] === 1'b0) break;
        end
        check("status_cmp", rd, 32'h1);
        check("irq_off", o_fault_irq, 32'h0);
        // Software trigger through the pin's port bit
        i_far.set_pin(1'b0);
        repeat (10) @(posedge i_clk);
        wr(ADDR_CTRL_D, 32'h94);
        wr(ADDR_COM_MODE, 32'hFF);
        wr(ADDR_PORT_B, 32'h2B);
        @(posedge i_clk);
        #1;
        check("pin_drive", o_ext_pin_drive, 32'h1);
        repeat (20) @(posedge i_clk);
        rd_check("sw_trig", ADDR_STATUS, 32'h1);
        check("pins_sw", o_pwm_pins, 32'h2B);
        // Flag without protection enabled
        wr(ADDR_CTRL_D, 32'h14);
        wr(ADDR_PORT_B, 32'h2A);
        repeat (20) @(posedge i_clk);
        rd_check("flag_clr", ADDR_STATUS, 32'h0);
        wr(ADDR_PORT_B, 32'h2B);
        repeat (20) @(posedge i_clk);
        rd_check("flag_noen", ADDR_STATUS, 32'h1);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        stop_test();
    end
endmodule
